// ---- hdl/sbsc_pkg.sv ----
// shared constants and types for the synchronous burst sram input control
package sbsc_pkg;

    // documented lane organisation: lanes a through h, byte plus parity
    localparam int LANES_DEF = 8;
    localparam int BYTE_W = 8;
    localparam int PAR_W = 1;
    localparam int LANE_W = BYTE_W + PAR_W;

    // two low-order address bits run the burst
    localparam int BURST_W = 2;
    // word address width default kept small for simulation
    localparam int ADDR_W_DEF = 10;

    localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
    localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;

    // reset values
    localparam logic MODE_INTERLEAVED = 1'h1;
    localparam logic SEL_RESET = 1'h0;

    // operation carried by the current access or burst
    typedef enum logic [1:0] {
        OP_IDLE,
        OP_READ,
        OP_WRITE
    } sbsc_op_e;

endpackage

// ---- hdl/sbsc_mem_if.sv ----
// carrier between the input control and its storage array
`timescale 1ns/100ps
`default_nettype none

interface sbsc_mem_if #(
    parameter int AW = 10,
    parameter int LANES = 8,
    parameter int LW = 9
);
    logic [AW-1:0] wr_addr;
    logic wr_en;
    logic [LANES-1:0] wr_lane_en;
    logic [LANES*LW-1:0] wr_word;
    logic [AW-1:0] rd_addr;
    logic rd_en;
    logic [LANES*LW-1:0] rd_word;

    modport ctrl (
        output wr_addr, wr_en, wr_lane_en, wr_word, rd_addr, rd_en,
        input rd_word
    );
    modport mem (
        input wr_addr, wr_en, wr_lane_en, wr_word, rd_addr, rd_en,
        output rd_word
    );
endinterface

`default_nettype wire

// ---- hdl/sbsc_mem.sv ----
// storage array with per-lane write enables and a registered read port
`timescale 1ns/100ps
`default_nettype none

module sbsc_mem #(
    parameter int AW = 10,
    parameter int LANES = 8,
    parameter int LW = 9
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // array access
    sbsc_mem_if.mem mif
);

    logic [LANES*LW-1:0] store [0:(1<<AW)-1];
    logic [LANES*LW-1:0] rd_word_r;

    // only enabled lanes change; the rest of the word is kept
    always_ff @(posedge clk_sys) begin
        if (mif.wr_en) begin
            for (int i = 0; i < LANES; i++) begin
                if (mif.wr_lane_en[i]) begin
                    store[mif.wr_addr][i*LW +: LW] <= mif.wr_word[i*LW +: LW];
                end
            end
        end
    end

    // read word holds between reads so a stretched cycle keeps its data
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rd_word_r <= '0;
        end else if (mif.rd_en) begin
            rd_word_r <= store[mif.rd_addr];
        end
    end

    assign mif.rd_word = rd_word_r;

endmodule // sbsc_mem

`default_nettype wire

// ---- hdl/sbsc_ctrl.sv ----
// synchronous input control of a pipelined burst sram, with its storage
`timescale 1ns/100ps
`default_nettype none

// How it works
// - inputs taken only at rising edge, and only with qualifier low
// - qualifier high: edge ignored, nothing sampled, previous cycle extended
// - address and two burst bits latched at the edge select one word
// - byte selects active low, each gates its byte and parity bit
// - write strobe active low, sampled on qualified edges, starts a write
// - byte selects write nothing unless write strobe was asserted at the load that began the burst
// - advance/load high on qualified edge steps burst counter inside a burst
// - advance/load low loads the presented address as a new access
// - first chip select active low, sampled at the edge
// - second chip select active high, sampled at the edge
// - third chip select active low, sampled at the edge
// - qualifier high does not deselect; state is frozen
// - strap picks interleaved (high) or linear (low) burst order
module sbsc_ctrl #(
    parameter int AW = sbsc_pkg::ADDR_W_DEF,
    parameter int LANES = sbsc_pkg::LANES_DEF
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // burst order strap
    input wire logic burst_order_strap,
    // address
    input wire logic [AW-sbsc_pkg::BURST_W-1:0] addr_upper,
    input wire logic burst_addr_bit_one,
    input wire logic burst_addr_bit_zero,
    // command
    input wire logic [LANES-1:0] byte_lane_write_sel_n,
    input wire logic write_en_n,
    input wire logic advance_or_load,
    input wire logic clock_qualifier_n,
    // chip selects
    input wire logic chip_sel_a_n,
    input wire logic chip_sel_b,
    input wire logic chip_sel_c_n,
    // write data
    input wire logic [LANES*sbsc_pkg::BYTE_W-1:0] wr_lane_data,
    input wire logic [LANES-1:0] parity_lane_in,
    // read data
    output logic [LANES*sbsc_pkg::BYTE_W-1:0] rd_lane_data,
    output logic [LANES-1:0] parity_lane_out,
    output logic rd_valid,
    // status
    output logic device_selected,
    output logic interleaved_mode,
    output logic [AW-1:0] cur_word_addr
);

    localparam int BW = sbsc_pkg::BURST_W;
    localparam int UW = AW - BW;
    localparam int DW = sbsc_pkg::BYTE_W;
    localparam int LW = sbsc_pkg::LANE_W;

    // next burst offset in the chosen order
    function automatic logic [BW-1:0] burst_low(
        input logic [BW-1:0] start,
        input logic [BW-1:0] count,
        input logic interleave
    );
        logic [BW-1:0] res;
        res = interleave ? (start ^ count) : BW'(start + count);
        return res;
    endfunction

    // pack one lane: parity bit above its data byte
    function automatic logic [LW-1:0] lane_pack(
        input logic par,
        input logic [DW-1:0] data
    );
        logic [LW-1:0] res;
        res = {par, data};
        return res;
    endfunction

    // data byte of one stored lane
    function automatic logic [DW-1:0] lane_byte(
        input logic [LW-1:0] lane
    );
        logic [DW-1:0] res;
        res = lane[DW-1:0];
        return res;
    endfunction

    // parity bit of one stored lane
    function automatic logic lane_par(
        input logic [LW-1:0] lane
    );
        logic res;
        res = lane[DW];
        return res;
    endfunction

    // true when the access of this edge carries the given operation
    function automatic logic op_is(
        input sbsc_pkg::sbsc_op_e op,
        input sbsc_pkg::sbsc_op_e want
    );
        logic res;
        res = (op == want);
        return res;
    endfunction

    // clock qualification and decode of this edge
    logic qual;
    logic sel_now;
    logic do_load;
    logic do_adv;

    // strap capture
    logic mode_r;
    logic mode_taken_r;
    logic mode_eff;

    // burst and operation state
    sbsc_pkg::sbsc_op_e op_r;
    sbsc_pkg::sbsc_op_e op_nxt;
    sbsc_pkg::sbsc_op_e acc_op;
    logic [AW-1:0] base_r;
    logic [BW-1:0] cnt_r;
    logic [BW-1:0] cnt_step;
    logic [AW-1:0] pres_addr;
    logic [AW-1:0] acc_addr;
    logic [AW-1:0] adv_addr;
    logic [AW-1:0] cur_addr_r;
    logic sel_r;

    // write pipeline
    logic [LANES-1:0] acc_lane_en;
    logic wr_pend_r;
    logic [AW-1:0] wr_addr_r;
    logic [LANES-1:0] wr_lane_en_r;
    logic [LANES*LW-1:0] wr_word;

    // read side
    logic rd_valid_r;

    sbsc_mem_if #(.AW(AW), .LANES(LANES), .LW(LW)) mif ();

    assign qual = !clock_qualifier_n;

    assign sel_now = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;

    assign do_load = qual && !advance_or_load;

    assign do_adv = qual && advance_or_load;

    assign pres_addr = {addr_upper, burst_addr_bit_one, burst_addr_bit_zero};
    assign cnt_step = BW'(cnt_r + sbsc_pkg::BURST_STEP);

    // strap is only trusted from release of reset onward; it must not change later
    assign mode_eff = mode_taken_r ? mode_r : burst_order_strap;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            mode_r <= sbsc_pkg::MODE_INTERLEAVED;
            mode_taken_r <= 1'h0;
        end else if (!mode_taken_r) begin
            mode_r <= burst_order_strap;
            mode_taken_r <= 1'h1;
        end
    end

    // operation of the access taken at this edge
    always_comb begin
        op_nxt = op_r;
        if (sel_now) begin
            op_nxt = write_en_n ? sbsc_pkg::OP_READ : sbsc_pkg::OP_WRITE;
        end else begin
            op_nxt = sbsc_pkg::OP_IDLE;
        end
    end

    // an advance keeps the burst's own operation; after a deselect it stays idle
    assign acc_op = do_load ? op_nxt : op_r;

    // next word of the running burst; the upper word address never moves inside a burst
    assign adv_addr = {base_r[AW-1:BW], burst_low(base_r[BW-1:0], cnt_step, mode_eff)};

    assign acc_addr = do_load ? pres_addr : adv_addr;

    assign acc_lane_en = op_is(acc_op, sbsc_pkg::OP_WRITE) ? ~byte_lane_write_sel_n : '0;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            op_r <= sbsc_pkg::OP_IDLE;
            sel_r <= sbsc_pkg::SEL_RESET;
        end else if (do_load) begin
            op_r <= op_nxt;
            sel_r <= sel_now;
        end
    end

    // counter steps only inside a burst
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            base_r <= '0;
            cnt_r <= sbsc_pkg::BURST_ZERO;
        end else if (do_load) begin
            base_r <= pres_addr;
            cnt_r <= sbsc_pkg::BURST_ZERO;
        end else if (do_adv && op_r != sbsc_pkg::OP_IDLE) begin
            cnt_r <= cnt_step;
        end
    end

    // an advance on an idle device leaves the reported address where it was
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cur_addr_r <= '0;
        end else if (qual && acc_op != sbsc_pkg::OP_IDLE) begin
            cur_addr_r <= acc_addr;
        end
    end

    // write data follows its command by one qualified edge
    // strobe starts write sequence
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wr_pend_r <= 1'h0;
            wr_addr_r <= '0;
            wr_lane_en_r <= '0;
        end else if (qual) begin
            wr_pend_r <= op_is(acc_op, sbsc_pkg::OP_WRITE);
            wr_addr_r <= acc_addr;
            wr_lane_en_r <= acc_lane_en;
        end
    end

    // byte and parity share a lane
    always_comb begin
        wr_word = '0;
        // lanes with their select high are still packed; the lane enable masks them
        for (int i = 0; i < LANES; i++) begin
            wr_word[i*LW +: LW] = lane_pack(parity_lane_in[i], wr_lane_data[i*DW +: DW]);
        end
    end

    // a read issued on the edge that retires a write to the same word sees the old
    // contents; the controller must not rely on forwarding
    assign mif.wr_en = qual && wr_pend_r;
    assign mif.wr_addr = wr_addr_r;
    assign mif.wr_lane_en = wr_lane_en_r;
    assign mif.wr_word = wr_word;
    assign mif.rd_en = qual && op_is(acc_op, sbsc_pkg::OP_READ);
    assign mif.rd_addr = acc_addr;

    sbsc_mem #(.AW(AW), .LANES(LANES), .LW(LW)) u_mem (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .mif(mif)
    );

    // read data valid holds through a stretched cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rd_valid_r <= 1'h0;
        end else if (qual) begin
            rd_valid_r <= op_is(acc_op, sbsc_pkg::OP_READ);
        end
    end

    // read word split back into bytes and parity; only wiring follows the flop
    always_comb begin
        rd_lane_data = '0;
        parity_lane_out = '0;
        for (int i = 0; i < LANES; i++) begin
            rd_lane_data[i*DW +: DW] = lane_byte(mif.rd_word[i*LW +: LW]);
            parity_lane_out[i] = lane_par(mif.rd_word[i*LW +: LW]);
        end
    end

    assign rd_valid = rd_valid_r;
    assign device_selected = sel_r;
    assign interleaved_mode = mode_r;
    assign cur_word_addr = cur_addr_r;

endmodule // sbsc_ctrl

`default_nettype wire

// ---- tb/sbsc_ctrl_asserts.sv ----
// port assertions for the burst sram input control
`timescale 1ns/100ps
`default_nettype none

module sbsc_ctrl_asserts #(
    parameter int AW = 10
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // inputs
    input wire logic burst_order_strap,
    input wire logic [AW-sbsc_pkg::BURST_W-1:0] addr_upper,
    input wire logic burst_addr_bit_one,
    input wire logic burst_addr_bit_zero,
    input wire logic write_en_n,
    input wire logic advance_or_load,
    input wire logic clock_qualifier_n,
    input wire logic chip_sel_a_n,
    input wire logic chip_sel_b,
    input wire logic chip_sel_c_n,
    // outputs
    input wire logic rd_valid,
    input wire logic device_selected,
    input wire logic interleaved_mode,
    input wire logic [AW-1:0] cur_word_addr
);
    logic go;
    logic ld;
    logic sel;
    assign go = !clock_qualifier_n;
    assign ld = go && !advance_or_load;
    assign sel = !chip_sel_a_n && chip_sel_b && !chip_sel_c_n;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_frozen_edge: assert property (
        !go |=> $stable({rd_valid, device_selected, cur_word_addr})) else $error("moved on idle edge");
    a_select_decode: assert property (
        ld |=> device_selected == $past(sel)) else $error("select decode wrong");
    a_read_or_write: assert property (
        ld && sel |=> rd_valid == $past(write_en_n)) else $error("read valid wrong after load");
    a_deselect_idle: assert property (
        ld && !sel |-> ##1 !rd_valid) else $error("read valid while deselected");
    a_load_addr: assert property (
        ld && sel |=> cur_word_addr == $past({addr_upper, burst_addr_bit_one, burst_addr_bit_zero}))
        else $error("loaded address wrong");
    a_adv_step: assert property (
        go && advance_or_load && rd_valid |=> rd_valid && (cur_word_addr[AW-1:2] ==
        $past(cur_word_addr[AW-1:2])) && (cur_word_addr[1:0] != $past(cur_word_addr[1:0])))
        else $error("burst step wrong");
    a_idle_adv: assert property (
        go && advance_or_load && !device_selected |=> !device_selected && !rd_valid)
        else $error("advance woke idle device");
    a_strap_held: assert property (
        $past(rst_b) |-> interleaved_mode == burst_order_strap) else $error("burst mode wrong");
endmodule // sbsc_ctrl_asserts

bind sbsc_ctrl sbsc_ctrl_asserts #(.AW(AW)) i_sbsc_ctrl_asserts (.clk_sys, .rst_b,
    .burst_order_strap, .addr_upper, .burst_addr_bit_one, .burst_addr_bit_zero, .write_en_n,
    .advance_or_load, .clock_qualifier_n, .chip_sel_a_n, .chip_sel_b, .chip_sel_c_n, .rd_valid,
    .device_selected, .interleaved_mode, .cur_word_addr);

`default_nettype wire

// ---- tb/sbsc_host_model.sv ----
// memory controller model driving the sram command and data inputs
`timescale 1ns/100ps
`default_nettype none

module sbsc_host_model #(
    parameter int AW = 10
) (
    // clock
    input wire logic clk_sys,
    // command
    output logic [AW-3:0] addr_upper,
    output logic burst_addr_bit_one,
    output logic burst_addr_bit_zero,
    output logic [7:0] byte_lane_write_sel_n,
    output logic write_en_n,
    output logic advance_or_load,
    output logic clock_qualifier_n,
    output logic chip_sel_a_n,
    output logic chip_sel_b,
    output logic chip_sel_c_n,
    // write data
    output logic [63:0] wr_lane_data,
    output logic [7:0] parity_lane_in
);
    // one beat, cmd = {qualifier_n, sel_a_n, sel_b, sel_c_n, advance, write_n}
    task automatic beat(input logic [5:0] cmd, input logic [AW-1:0] a,
            input logic [7:0] bw, input logic [71:0] d);
        @(posedge clk_sys);
        #1;
        {clock_qualifier_n, chip_sel_a_n, chip_sel_b, chip_sel_c_n, advance_or_load, write_en_n} = cmd;
        {addr_upper, burst_addr_bit_one, burst_addr_bit_zero} = a;
        byte_lane_write_sel_n = bw;
        {parity_lane_in, wr_lane_data} = d;
    endtask

    // starts deselected with a load pending, so nothing is read or written before the first beat
    initial begin
        {clock_qualifier_n, chip_sel_a_n, chip_sel_b, chip_sel_c_n, advance_or_load, write_en_n} = 6'h11;
        {addr_upper, burst_addr_bit_one, burst_addr_bit_zero} = '0;
        byte_lane_write_sel_n = 8'hFF;
        {parity_lane_in, wr_lane_data} = '0;
    end
endmodule // sbsc_host_model

`default_nettype wire

// ---- tb/sbsc_ctrl_test.sv ----
// self-checking bench for the burst sram input control
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module sbsc_ctrl_test;
    localparam int AW = 10;
    localparam logic [5:0] RD = 6'h09;
    localparam logic [5:0] WR = 6'h08;
    localparam logic [5:0] ADV = 6'h0B;
    localparam logic [5:0] DES = 6'h11;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic strap = 1'b1;
    logic [AW-3:0] au;
    logic b1, b0, we_n, adv, q_n, ca_n, cb, cc_n, rv, dsel, il;
    logic [7:0] bw_n, pin, pout;
    logic [63:0] din, dout;
    logic [AW-1:0] cur, a;
    logic [71:0] ref_m [int];
    int seed = 32'hda7a026d;
    int num_errors = 0;
    int checks_done = 0;

    always #4 clk_sys = ~clk_sys;

    sbsc_ctrl #(.AW(AW), .LANES(8)) i_sbsc_ctrl (.clk_sys(clk_sys), .rst_b(rst_b),
        .burst_order_strap(strap), .addr_upper(au), .burst_addr_bit_one(b1),
        .burst_addr_bit_zero(b0), .byte_lane_write_sel_n(bw_n), .write_en_n(we_n),
        .advance_or_load(adv), .clock_qualifier_n(q_n), .chip_sel_a_n(ca_n), .chip_sel_b(cb),
        .chip_sel_c_n(cc_n), .wr_lane_data(din), .parity_lane_in(pin), .rd_lane_data(dout),
        .parity_lane_out(pout), .rd_valid(rv), .device_selected(dsel), .interleaved_mode(il),
        .cur_word_addr(cur));
    sbsc_host_model #(.AW(AW)) i_sbsc_host_model (.clk_sys(clk_sys), .addr_upper(au),
        .burst_addr_bit_one(b1), .burst_addr_bit_zero(b0), .byte_lane_write_sel_n(bw_n),
        .write_en_n(we_n), .advance_or_load(adv), .clock_qualifier_n(q_n), .chip_sel_a_n(ca_n),
        .chip_sel_b(cb), .chip_sel_c_n(cc_n), .wr_lane_data(din), .parity_lane_in(pin));

    function automatic logic [71:0] rnd();
        return 72'({$random(seed), $random(seed), $random(seed)});
    endfunction
    function automatic logic [AW-1:0] bur(logic [AW-1:0] s, int k);
        bur = s;
        bur[1:0] = strap ? s[1:0] ^ 2'(k) : s[1:0] + 2'(k);
    endfunction
    function automatic logic [71:0] merge(logic [71:0] o, logic [71:0] n, logic [7:0] bw);
        for (int i = 0; i < 8; i++) begin
            if (!bw[i]) begin
                o[i*8+:8] = n[i*8+:8];
                o[64+i] = n[64+i];
            end
        end
        return o;
    endfunction
    task automatic step(input logic [5:0] c, input logic [AW-1:0] x, input logic [7:0] bw = 8'h00);
        i_sbsc_host_model.beat(c, x, bw, rnd());
    endtask
    task automatic rd_chk(input logic [AW-1:0] x);
        `CHK({rv, cur, pout, dout}, {1'b1, x, ref_m[x]})
    endtask
    task automatic finish_test();
        $display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        #100000;
        num_errors++;
        finish_test();
    end

    initial begin
        logic [71:0] d;
        logic [7:0] m;
        for (int md = 1; md >= 0; md--) begin
            strap = md[0];
            rst_b = 1'b0;
            repeat (16) @(posedge clk_sys);
            #1 rst_b = 1'b1;
            `CHK({rv, dsel, cur}, '0)
            // a defined address keeps the selected load below free of unknowns
            a = AW'($random(seed));
            for (int c = 0; c < 8; c++) begin
                step({1'b0, 3'(c), 2'b01}, a);
                step(DES, a);
                `CHK({dsel, rv}, {2{c == 2}})
            end
            `CHK(il, strap)
            $display("select decode done");
            for (int n = 0; n < 20; n++) begin
                a = AW'($random(seed));
                m = 8'($random(seed));
                d = rnd();
                step(WR, a);
                i_sbsc_host_model.beat(DES, a, 8'h00, d);
                ref_m[a] = d;
                d = rnd();
                step(WR, a, m);
                step(6'h20 | 6'($random(seed)), a);
                // data beat closes with a load, never an advance
                i_sbsc_host_model.beat(DES, a, 8'h00, d);
                ref_m[a] = merge(ref_m[a], d, m);
                step(RD, a);
                step(6'h2B, a);
                rd_chk(a);
                step(DES, a);
                rd_chk(a);
                // the read above had every byte select low; the word must be untouched
                step(RD, a);
                step(DES, a);
                rd_chk(a);
            end
            $display("write mask and freeze done");
            for (int n = 0; n < 8; n++) begin
                a = AW'($random(seed));
                step(WR, a);
                for (int k = 0; k < 4; k++) begin
                    d = rnd();
                    i_sbsc_host_model.beat(k < 3 ? ADV : DES, a, 8'h00, d);
                    ref_m[bur(a, k)] = d;
                end
                step(RD, a);
                for (int k = 1; k < 4; k++) begin
                    step(ADV, a);
                    rd_chk(bur(a, k - 1));
                end
                step(DES, a);
                rd_chk(bur(a, 3));
                step(ADV, a);
                step(DES, a);
                `CHK({rv, dsel}, 2'h0)
            end
            $display("burst pass done");
        end
        finish_test();
    end
endmodule // sbsc_ctrl_test

`default_nettype wire
